// ### two_wire_slave.sv
// What this block does
// R1: both lines high means idle, stay released
// R2: data falling while clock high starts
// R3: data rising while clock high stops
// R4: byte count unlimited, master decides; write bytes are left unacknowledged while the 8-entry write buffer is full
// R5: acknowledge by holding data low ninth clock
// R6: master ends read with not-acknowledge
// R7: master sends high-speed code first after start
// R8: leave code unacknowledged, switch filters high-speed
// R9: master follows code with slave address
// R10: stay high-speed until stop, then fast
// R11: address from two select pins, default 1000000
// R12: master releases data after second read byte
// R13: address byte is seven bits plus direction
// R14: first write byte loads register pointer
// R15: reads use last written pointer, kept
// R16: words sent high byte first, bits msb first
// R17: ignore foreign addresses until next start
// R18: drive data only as open-drain pull-low
`timescale 1ns/1ps
`include "two_wire_consts.svh"

module two_wire_slave (
    input  wire logic                 clk_sys_i,
    input  wire logic                 resetn_i,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    input  wire logic                 address_select_pin_high_i,
    input  wire logic                 address_select_pin_low_i,
    output logic                      hs_mode_o,
    output logic [7:0]                ptr_o,
    input  wire logic [15:0]          rd_data_i,
    output logic                      rd_strobe_o,
    output logic                      wr_valid_o,
    input  wire logic                 wr_ready_i,
    output two_wire_pkg::wr_item_t    wr_item_o
);

    // ****************************************
    // pin synchronisers and spike filters
    // ****************************************
    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic [1:0] filt_r;
    logic [`FILT_CNT_W-1:0] flim;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_r <= 4'hF;
            sync_r <= 4'hF;
        end else begin
            meta_r <= {address_select_pin_high_i, address_select_pin_low_i, sda_i, scl_i};
            sync_r <= meta_r;
        end
    end

    // R8: filter length follows mode
    assign flim = hs_mode_o ? `FILT_CNT_W'(`FILT_HS_CYC) : `FILT_CNT_W'(`FILT_FS_CYC);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            logic [`FILT_CNT_W-1:0] cnt_r;
            logic [`FILT_CNT_W-1:0] cnt_nxt;
            logic                   val_nxt;
            always_comb begin
                cnt_nxt = '0;
                val_nxt = filt_r[gi];
                if (sync_r[gi] != filt_r[gi]) begin
                    if (cnt_r + 1'b1 >= flim) begin
                        val_nxt = sync_r[gi];
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end
            always_ff @(posedge clk_sys_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    cnt_r      <= '0;
                    filt_r[gi] <= 1'b1;
                end else begin
                    cnt_r      <= cnt_nxt;
                    filt_r[gi] <= val_nxt;
                end
            end
        end
    endgenerate

    // ****************************************
    // bus events
    // ****************************************
    logic       scl_d_r;
    logic       sda_d_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [6:0] own_addr;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= filt_r[0];
            sda_d_r <= filt_r[1];
        end
    end

    assign scl_rise  = filt_r[0] && !scl_d_r;
    assign scl_fall  = !filt_r[0] && scl_d_r;
    // R2: start detect
    assign start_det = filt_r[0] && scl_d_r && sda_d_r && !filt_r[1];
    // R3: stop detect
    assign stop_det  = filt_r[0] && scl_d_r && !sda_d_r && filt_r[1];
    // R11: pin strapped address
    assign own_addr  = {`ADDR_BASE, sync_r[3], sync_r[2]};

    // ****************************************
    // serial engine
    // ****************************************
    two_wire_pkg::slave_state_t state_r;
    two_wire_pkg::slave_state_t state_nxt;
    logic [`BIT_CNT_W-1:0]      bcnt_r;
    logic [`BIT_CNT_W-1:0]      bcnt_nxt;
    logic [7:0]                 shift_r;
    logic [7:0]                 shift_nxt;
    logic [7:0]                 lsb_r;
    logic [7:0]                 lsb_nxt;
    logic                       first_r;
    logic                       first_nxt;
    logic                       ptr_phase_r;
    logic                       ptr_phase_nxt;
    logic                       tx_high_r;
    logic                       tx_high_nxt;
    logic                       ack_ok_r;
    logic                       ack_ok_nxt;
    logic                       hs_nxt;
    logic                       oe_nxt;
    logic [7:0]                 ptr_nxt;
    logic                       strobe_nxt;
    logic                       whigh_r;
    logic                       whigh_nxt;
    logic                       push;
    logic                       fifo_ready;
    two_wire_pkg::wr_item_t     item;

    always_comb begin
        state_nxt     = state_r;
        bcnt_nxt      = bcnt_r;
        shift_nxt     = shift_r;
        lsb_nxt       = lsb_r;
        first_nxt     = first_r;
        ptr_phase_nxt = ptr_phase_r;
        tx_high_nxt   = tx_high_r;
        ack_ok_nxt    = ack_ok_r;
        hs_nxt        = hs_mode_o;
        oe_nxt        = sda_oe_o;
        ptr_nxt       = ptr_o;
        strobe_nxt    = 1'b0;
        whigh_nxt     = whigh_r;
        push          = 1'b0;
        item          = '{ptr: ptr_o, data: shift_r, high_byte: whigh_r};
        if (stop_det) begin
            // R10: stop returns to fast filtering
            hs_nxt    = 1'b0;
            // R1: release on idle
            oe_nxt    = 1'b0;
            state_nxt = two_wire_pkg::ST_IDLE;
        end else if (start_det) begin
            // R2: repeated start also restarts address phase
            state_nxt = two_wire_pkg::ST_ADDR;
            bcnt_nxt  = `BIT_CNT_ZERO;
            first_nxt = !hs_mode_o;
            oe_nxt    = 1'b0;
        end else begin
            case (state_r)
                two_wire_pkg::ST_IDLE: begin
                    oe_nxt = 1'b0;
                end
                two_wire_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], filt_r[1]};
                        bcnt_nxt  = bcnt_r + `BIT_CNT_ONE;
                    end else if (scl_fall && bcnt_r == `BYTE_BITS) begin
                        // R13: seven address bits then direction
                        if (first_r && shift_r[7:1] == `HS_MASTER_CODE) begin
                            // R8: no acknowledge, enter high-speed
                            hs_nxt    = 1'b1;
                            state_nxt = two_wire_pkg::ST_IDLE;
                        end else if (shift_r[7:1] == own_addr) begin
                            // R5: acknowledge address
                            oe_nxt     = 1'b1;
                            ack_ok_nxt = shift_r[0];
                            state_nxt  = two_wire_pkg::ST_ADDR_ACK;
                        end else begin
                            // R17: foreign address ignored
                            state_nxt = two_wire_pkg::ST_IDLE;
                        end
                    end
                end
                two_wire_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bcnt_nxt = `BIT_CNT_ZERO;
                        if (ack_ok_r) begin
                            // R15: read word at held pointer
                            // R16: high byte first, msb first
                            shift_nxt   = rd_data_i[15:8];
                            lsb_nxt     = rd_data_i[7:0];
                            strobe_nxt  = 1'b1;
                            tx_high_nxt = 1'b1;
                            // R18: pull low only for zero bits
                            oe_nxt      = !rd_data_i[15];
                            state_nxt   = two_wire_pkg::ST_TX;
                        end else begin
                            oe_nxt        = 1'b0;
                            ptr_phase_nxt = 1'b1;
                            state_nxt     = two_wire_pkg::ST_RX;
                        end
                    end
                end
                two_wire_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], filt_r[1]};
                        bcnt_nxt  = bcnt_r + `BIT_CNT_ONE;
                    end else if (scl_fall && bcnt_r == `BYTE_BITS) begin
                        state_nxt = two_wire_pkg::ST_RX_ACK;
                        if (ptr_phase_r) begin
                            // R14: first write byte is pointer
                            ptr_nxt       = shift_r;
                            ptr_phase_nxt = 1'b0;
                            whigh_nxt     = 1'b1;
                            oe_nxt        = 1'b1;
                        end else if (fifo_ready) begin
                            // R4: bytes accepted while the write buffer has room
                            push      = 1'b1;
                            whigh_nxt = !whigh_r;
                            oe_nxt    = 1'b1;
                        end
                        // full buffer leaves byte unacknowledged
                    end
                end
                two_wire_pkg::ST_RX_ACK: begin
                    if (scl_fall) begin
                        oe_nxt    = 1'b0;
                        bcnt_nxt  = `BIT_CNT_ZERO;
                        state_nxt = two_wire_pkg::ST_RX;
                    end
                end
                two_wire_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bcnt_r == `BIT_LAST) begin
                            oe_nxt    = 1'b0;
                            state_nxt = two_wire_pkg::ST_TX_ACK;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_nxt    = !shift_r[6];
                            bcnt_nxt  = bcnt_r + `BIT_CNT_ONE;
                        end
                    end
                end
                two_wire_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        ack_ok_nxt = !filt_r[1];
                    end else if (scl_fall) begin
                        bcnt_nxt = `BIT_CNT_ZERO;
                        if (!ack_ok_r) begin
                            // R6: not-acknowledge ends the read
                            state_nxt = two_wire_pkg::ST_IDLE;
                        end else if (tx_high_r) begin
                            shift_nxt   = lsb_r;
                            tx_high_nxt = 1'b0;
                            oe_nxt      = !lsb_r[7];
                            state_nxt   = two_wire_pkg::ST_TX;
                        end else begin
                            // R4: master may keep reading words
                            shift_nxt   = rd_data_i[15:8];
                            lsb_nxt     = rd_data_i[7:0];
                            strobe_nxt  = 1'b1;
                            tx_high_nxt = 1'b1;
                            oe_nxt      = !rd_data_i[15];
                            state_nxt   = two_wire_pkg::ST_TX;
                        end
                    end
                end
                default: begin
                    oe_nxt    = 1'b0;
                    state_nxt = two_wire_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r     <= two_wire_pkg::ST_IDLE;
            bcnt_r      <= `BIT_CNT_ZERO;
            shift_r     <= 8'h00;
            lsb_r       <= 8'h00;
            first_r     <= 1'b0;
            ptr_phase_r <= 1'b0;
            tx_high_r   <= 1'b0;
            ack_ok_r    <= 1'b0;
            hs_mode_o   <= 1'b0;
            sda_oe_o    <= 1'b0;
            ptr_o       <= 8'h00;
            rd_strobe_o <= 1'b0;
            whigh_r     <= 1'b1;
        end else begin
            state_r     <= state_nxt;
            bcnt_r      <= bcnt_nxt;
            shift_r     <= shift_nxt;
            lsb_r       <= lsb_nxt;
            first_r     <= first_nxt;
            ptr_phase_r <= ptr_phase_nxt;
            tx_high_r   <= tx_high_nxt;
            ack_ok_r    <= ack_ok_nxt;
            hs_mode_o   <= hs_nxt;
            sda_oe_o    <= oe_nxt;
            ptr_o       <= ptr_nxt;
            rd_strobe_o <= strobe_nxt;
            whigh_r     <= whigh_nxt;
        end
    end

    // R18: open-drain, low level only
    assign sda_o = 1'b0;

    // ****************************************
    // write buffer
    // ****************************************
    byte_fifo #(
        .WIDTH (`ITEM_W),
        .DEPTH (`FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (item),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  (wr_item_o)
    );

endmodule // two_wire_slave

// ### two_wire_consts.svh
`ifndef TWO_WIRE_CONSTS_SVH
`define TWO_WIRE_CONSTS_SVH

// ****************************************
// clocking and filter timing
// ****************************************
`define CLK_PERIOD_NS   8
`define FILT_FS_NS      24
`define FILT_HS_NS      8
`define FILT_FS_CYC     (((`FILT_FS_NS) / (`CLK_PERIOD_NS)) < 1 ? 1 : \
                         ((`FILT_FS_NS) / (`CLK_PERIOD_NS)))
`define FILT_HS_CYC     (((`FILT_HS_NS) / (`CLK_PERIOD_NS)) < 1 ? 1 : \
                         ((`FILT_HS_NS) / (`CLK_PERIOD_NS)))
`define FILT_CNT_W      3

// ****************************************
// protocol values
// ****************************************
`define ADDR_BASE       5'h10
`define HS_MASTER_CODE  7'h04
`define BIT_CNT_W       4
`define BIT_CNT_ZERO    4'h0
`define BIT_CNT_ONE     4'h1
`define BIT_LAST        4'h7
`define BYTE_BITS       4'h8

// ****************************************
// write buffer
// ****************************************
`define ITEM_W          17
`define FIFO_DEPTH      8

`endif

// ### two_wire_pkg.sv
package two_wire_pkg;

    // ****************************************
    // write stream item
    // ****************************************
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
        logic       high_byte;
    } wr_item_t;

    // ****************************************
    // serial engine states
    // ****************************************
    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ADDR     = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_RX       = 7'h08,
        ST_RX_ACK   = 7'h10,
        ST_TX       = 7'h20,
        ST_TX_ACK   = 7'h40
    } slave_state_t;

endpackage

// ### byte_fifo.sv
`timescale 1ns/1ps

module byte_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys_i,
    input  wire logic             resetn_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    wr_ptr_nxt;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW-1:0]    rd_ptr_nxt;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             push;
    logic             pop;

    // ****************************************
    // pointers and fill level
    // ****************************************
    always_comb begin
        push       = in_valid_i && in_ready_o;
        pop        = out_valid_o && out_ready_i;
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        if (push) begin
            wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
        end
        if (pop) begin
            rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
        end
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
        end
    end

    // storage has no reset; valid gating keeps stale words hidden
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];

endmodule // byte_fifo

// ### two_wire_slave_props.sv
`timescale 1ns/1ps

module two_wire_slave_props (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    input  wire logic        sda_o,
    input  wire logic        sda_oe_o,
    input  wire logic        hs_mode_o,
    input  wire logic [7:0]  ptr_o,
    input  wire logic [15:0] rd_data_i,
    input  wire logic        rd_strobe_o,
    input  wire logic        wr_valid_o
);
    // ****
    // cycles since a stop on the pins
    // ****
    logic [4:0] stop_age_r;
    logic       sda_d_r;

    // raw pins, so the figure includes the design's own filter delay
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sda_d_r    <= 1'b1;
            stop_age_r <= 5'h1F;
        end else begin
            sda_d_r <= sda_i;
            if (scl_i && sda_i && !sda_d_r)
                stop_age_r <= 5'h00;
            else if (stop_age_r != 5'h1F)
                stop_age_r <= stop_age_r + 5'h01;
        end
    end

    // ****
    // properties
    // ****
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_drive_low_only: assert property (sda_o == 1'b0)
        else $error("data output value is not low");
    a_oe_high_phase: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("data drive changed while clock high");
    a_code_no_ack: assert property ($rose(hs_mode_o) |=> !sda_oe_o [*8])
        else $error("master code was acknowledged");
    a_hs_until_stop: assert property ($fell(hs_mode_o) |-> stop_age_r < 5'h10)
        else $error("high speed left without a stop");
    a_stop_release: assert property (stop_age_r == 5'h0C |-> !sda_oe_o && !hs_mode_o)
        else $error("stop did not release the bus");
    a_word_msb: assert property (rd_strobe_o |-> sda_oe_o == !rd_data_i[15])
        else $error("first read bit is not the word msb");
    a_strobe_once: assert property (rd_strobe_o |=> !rd_strobe_o [*8])
        else $error("read strobes too close");
    a_ptr_at_ack: assert property ($changed(ptr_o) |-> $rose(sda_oe_o))
        else $error("pointer changed outside a byte ack");
    a_push_in_ack: assert property ($rose(wr_valid_o) |-> $rose(sda_oe_o))
        else $error("item stored without acknowledge");
endmodule // two_wire_slave_props

bind two_wire_slave two_wire_slave_props i_props (
    .clk_sys_i,
    .resetn_i,
    .scl_i,
    .sda_i,
    .sda_o,
    .sda_oe_o,
    .hs_mode_o,
    .ptr_o,
    .rd_data_i,
    .rd_strobe_o,
    .wr_valid_o
);

// ### two_wire_master_model.sv
`timescale 1ns/1ps

module two_wire_master_model (
    output logic      scl_o,
    output logic      sda_low_o,
    input  wire logic sda_i
);
    // ****
    // bus master, 80 ns bit, low 56 high 24
    // ****
    // idle released
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    // data moves mid low phase, away from the slave's filtered edges
    task automatic bit_io(input logic b, output logic r);
        #24 sda_low_o = !b;
        #32 scl_o = 1'b1;
        #16 r = sda_i;
        #8 scl_o = 1'b0;
    endtask

    task automatic start();
        if (!scl_o) begin
            #24 sda_low_o = 1'b0;
            #32 scl_o = 1'b1;
        end
        #24 sda_low_o = 1'b1;
        #24 scl_o = 1'b0;
    endtask

    task automatic stop();
        #24 sda_low_o = 1'b1;
        #32 scl_o = 1'b1;
        #24 sda_low_o = 1'b0;
        #80;
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic rd_byte(output logic [7:0] b, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(!ack, r);
    endtask
endmodule // two_wire_master_model

// ### test_two_wire_slave.sv
`timescale 1ns/1ps

module test_two_wire_slave;
    typedef struct packed {
        logic [1:0] pins;
        logic [7:0] addr;
        logic       ack;
    } row_t;

    logic                   clk_sys_i = 1'b0;
    logic                   resetn_i;
    logic                   scl_i;
    logic                   sda_low;
    logic                   sda_i;
    logic                   sda_o;
    logic                   sda_oe_o;
    logic                   address_select_pin_high_i;
    logic                   address_select_pin_low_i;
    logic                   hs_mode_o;
    logic [7:0]             ptr_o;
    logic [15:0]            rd_data_i;
    logic                   rd_strobe_o;
    logic                   wr_valid_o;
    logic                   wr_ready_i;
    two_wire_pkg::wr_item_t wr_item_o;
    logic                   ack;
    logic [7:0]             b;
    logic [7:0]             exp_ptr = 8'h00;
    int                     n_errors = 0;
    int                     tests_run = 0;
    int                     n_strobe = 0;
    row_t                   rows [6] = '{'{2'b00, 8'h80, 1'b1}, '{2'b01, 8'h82, 1'b1},
                                        '{2'b10, 8'h84, 1'b1}, '{2'b11, 8'h86, 1'b1},
                                        '{2'b11, 8'h80, 1'b0}, '{2'b00, 8'h82, 1'b0}};

    // pull-up wire; register contents follow the pointer
    assign sda_i     = !(sda_low || (sda_oe_o && !sda_o));
    assign rd_data_i = {ptr_o, ~ptr_o};
    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (rd_strobe_o === 1'b1)
            n_strobe++;
    end

    two_wire_slave i_dut (.clk_sys_i, .resetn_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
        .address_select_pin_high_i, .address_select_pin_low_i, .hs_mode_o, .ptr_o,
        .rd_data_i, .rd_strobe_o, .wr_valid_o, .wr_ready_i, .wr_item_o);
    two_wire_master_model i_mst (.scl_o(scl_i), .sda_low_o(sda_low), .sda_i(sda_i));

    // ****
    // compare and close
    // ****
    task automatic chk_b(input string what, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk_v(input string what, input logic [16:0] e, input logic [16:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // generous: whole run is about 30 us
    initial begin
        #300000;
        n_errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        end_of_test();
    end

    // ****
    // scenarios
    // ****
    initial begin
        resetn_i = 1'b0;
        {address_select_pin_high_i, address_select_pin_low_i} = 2'b00;
        wr_ready_i = 1'b0;
        repeat (10) @(posedge clk_sys_i);
        #1 resetn_i = 1'b1;
        chk_v("pointer", 17'h00000, 17'(ptr_o));
        chk_b("drive", 1'b0, sda_oe_o);
        chk_b("speed", 1'b0, hs_mode_o);
        repeat (4) @(posedge clk_sys_i);
        #1;
        for (int i = 0; i < 6; i++) begin
            {address_select_pin_high_i, address_select_pin_low_i} = rows[i].pins;
            repeat (4) @(posedge clk_sys_i);
            #1 i_mst.start();
            i_mst.wr_byte(rows[i].addr, ack);
            chk_b("address ack", rows[i].ack, ack);
            i_mst.wr_byte(8'(8'h11 * i), ack);
            chk_b("pointer ack", rows[i].ack, ack);
            i_mst.stop();
            if (rows[i].ack)
                exp_ptr = 8'(8'h11 * i);
            chk_v("pointer", 17'(exp_ptr), 17'(ptr_o));
        end
        // fill with consumer stalled: ninth byte refused
        i_mst.start();
        i_mst.wr_byte(8'h80, ack);
        i_mst.wr_byte(8'h5A, ack);
        for (int i = 0; i < 9; i++) begin
            i_mst.wr_byte(8'(8'hC3 + i), ack);
            chk_b("data ack", i < 8, ack);
        end
        i_mst.stop();
        @(posedge clk_sys_i);
        #1 wr_ready_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            chk_b("item valid", 1'b1, wr_valid_o);
            chk_v("item", {8'h5A, 8'(8'hC3 + i), !i[0]}, wr_item_o);
            @(posedge clk_sys_i);
            #1;
        end
        chk_b("item valid", 1'b0, wr_valid_o);
        // read past one word, end with not-acknowledge
        i_mst.start();
        i_mst.wr_byte(8'h81, ack);
        chk_b("read address ack", 1'b1, ack);
        for (int k = 0; k < 3; k++) begin
            i_mst.rd_byte(b, k < 2);
            chk_v("read byte", k[0] ? 17'h000A5 : 17'h0005A, 17'(b));
        end
        i_mst.stop();
        chk_v("words fetched", 17'h00002, 17'(n_strobe));
        chk_v("pointer", 17'h0005A, 17'(ptr_o));
        // both master code forms, repeated start inside high speed
        for (int x = 0; x < 2; x++) begin
            i_mst.start();
            i_mst.wr_byte(8'h08 | 8'(x), ack);
            chk_b("code ack", 1'b0, ack);
            chk_b("speed", 1'b1, hs_mode_o);
            i_mst.start();
            i_mst.wr_byte(8'h80, ack);
            chk_b("address ack", 1'b1, ack);
            i_mst.wr_byte(8'(8'h20 + x), ack);
            i_mst.start();
            chk_b("speed", 1'b1, hs_mode_o);
            i_mst.wr_byte(8'h81, ack);
            chk_b("address ack", 1'b1, ack);
            i_mst.rd_byte(b, 1'b0);
            chk_v("read byte", 17'(8'h20 + x), 17'(b));
            i_mst.stop();
            chk_b("speed", 1'b0, hs_mode_o);
        end
        end_of_test();
    end
endmodule // test_two_wire_slave
